/* File: dv/mtgs_link_master.sv */
// serial link master model: shift clock, frame sync, pin sampling
`timescale 1ns/10ps
`default_nettype none
module mtgs_link_master (
    output var  logic sclk,
    output var  logic sync,
    output var  logic rx_sclk,
    output var  logic rx_sync,
    input  wire logic cs,
    input  wire logic d,
    input  wire logic oe
);
    logic [1:0] smp[$];
    initial begin
        sclk = 1'b0;
        sync = 1'b0;
    end
    // receive pins held idle in clock stop
    assign rx_sclk = cs ? 1'b0 : sclk;
    assign rx_sync = cs ? 1'b0 : sync;
    // master owns clock, clock idle between frames
    task automatic run(input int ticks);
        smp = {};
        sync = ~cs;
        #130;
        for (int i = 0; i < ticks; i++) begin
            sclk = 1'b1;
            #200 sclk = 1'b0;
            if (!cs)
                sync = 1'b0;
            // sample just before the next rise, where the bit is settled
            #190 smp.push_back({oe, d});
            #10;
        end
        sync = cs;
    endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the multichannel transmit gating block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    mismatches++; $display("ERROR %0t: got %0h want %0h", $time, \
    a, e); end end
module tb;
    import mtgs_pkg::*;
    localparam logic [7:0] WORD = 8'ha5;
    logic clk;
    logic reset = 1'b1;
    logic cs = 1'b0;
    logic psel = 1'b0;
    logic rsel = 1'b0;
    logic wr = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [1:0] intm = 2'h1;
    logic seu = 1'b1;
    logic [2:0] wlen = 3'h0;
    logic [6:0] flen = 7'h3;
    logic [31:0] wd = 32'h0;
    logic [127:0] xb = '0;
    logic [127:0] rb = 128'h3;
    logic sclk, sync, rx_sclk, rx_sync, dout, doe, rdy, emp, dma;
    logic tirq, rirq;
    logic [6:0] tch;
    int mismatches = 0;
    int num_checks = 0;
    int dma_n, tirq_n, rirq_n;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    mtgs_top u_dut (
        .clk(clk), .reset(reset), .tx_shift_clock(sclk),
        .tx_frame_sync(sync), .rx_shift_clock(rx_sclk),
        .rx_frame_sync(rx_sync), .clock_stop_mode(cs),
        .slave_enable_used(seu), .tx_selection_mode(mode),
        .tx_partition_count_select(psel), .tx_phase_select(1'b0),
        .tx_frame_length(flen), .tx_word_length(wlen),
        .tx_interrupt_mode(intm), .tx_channel_enable_bits(xb),
        .rx_selection_mode(rsel), .rx_partition_count_select(psel),
        .rx_frame_length(flen), .rx_word_length(wlen),
        .rx_interrupt_mode(intm), .rx_channel_enable_bits(rb),
        .tx_write(wr), .tx_write_data(wd),
        .serial_data_out_pin_o(dout), .serial_data_out_pin_oe(doe),
        .tx_ready_flag(rdy), .tx_empty_flag(emp), .tx_dma_event(dma),
        .tx_interrupt_request(tirq), .rx_interrupt_request(rirq),
        .tx_channel(tch));

    mtgs_link_master u_link (
        .sclk(sclk), .sync(sync), .rx_sclk(rx_sclk), .rx_sync(rx_sync),
        .cs(cs), .d(dout), .oe(doe));

    always @(posedge clk) begin
        dma_n += int'(dma === 1'b1);
        tirq_n += int'(tirq === 1'b1);
        rirq_n += int'(rirq === 1'b1);
    end

    function automatic logic [1:0] gate(input int ch);
        int i;
        i = psel ? ch : ch % 32;
        case (mode)
            2'h0: return 2'h3;
            2'h1: return {xb[i], xb[i]};
            2'h2: return {1'b1, xb[i]};
            default: return {rb[i], rb[i] & xb[i]};
        endcase
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic frame(input logic [1:0] m, input logic [127:0] x,
                         input int words, input logic p, input logic c);
        int en, blk, ei, ti, ri;
        logic [1:0] g, s;
        @(posedge clk);
        mode <= m;
        xb <= x;
        psel <= p;
        cs <= c;
        rsel <= (m != 2'h0);
        // single phase, receive framing mirrors transmit
        flen <= 7'(words - 1);
        wr <= 1'b1;
        wd <= {24'hffffff, WORD};
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
        `CHK(rdy, 1'b0)
        dma_n = 0;
        tirq_n = 0;
        rirq_n = 0;
        u_link.run(words * 8 + 1);
        repeat (8) @(posedge clk);
        en = 0;
        blk = 0;
        // per-channel gate on the data pin
        for (int ch = 0; ch < words; ch++) begin
            g = gate(ch);
            en += int'(g[1]);
            blk += int'(ch % 16 == 15 || ch == words - 1);
            for (int b = 0; b < 8; b++) begin
                s = u_link.smp[ch * 8 + b];
                `CHK(s[1], g[1] & g[0])
                if (g[0])
                    `CHK(s[0], WORD[7 - b])
            end
        end
        ei = (m != 2'h0 && !c) ? 2 * blk : 0;
        // ready mode pulses once per copy; receive has no such mode
        ti = (intm == 2'h0) ? 2 * en : ei;
        ri = (intm == 2'h1) ? ei : 0;
        `CHK(u_link.smp[words * 8][1], 1'b0)
        `CHK(dma_n, en)
        `CHK(rdy, en > 0)
        `CHK(emp, en > 1)
        `CHK(tirq_n, ti)
        `CHK(rirq_n, ri)
        `CHK(tch, 7'(words - 1))
        $display("test mode %0h words %0d done", m, words);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK(doe, 1'b0)
        `CHK(rdy, MTGS_READY_RST)
        `CHK(emp, MTGS_EMPTY_RST)
        `CHK(tirq, 1'b0)
        for (int m = 0; m < 4; m++)
            frame(2'(m), 128'h5, 4, 1'b0, 1'b0);
        frame(2'h1, 128'h0, 4, 1'b0, 1'b0);
        intm <= 2'h0;
        frame(2'h1, 128'h5, 4, 1'b0, 1'b0);
        intm <= 2'h1;
        // past 32 channels: two partitions reuse the low bits, eight partitions do not wrap
        frame(2'h1, 128'h2_0005, 34, 1'b0, 1'b0);
        frame(2'h1, 128'h2_0005, 34, 1'b1, 1'b0);
        frame(2'h0, 128'h0, 1, 1'b0, 1'b1);
        seu <= 1'b0;
        frame(2'h0, 128'h0, 1, 1'b0, 1'b1);
        finish_test();
    end

    initial begin
        #1000000;
        mismatches++;
        finish_test();
    end
endmodule
`default_nettype wire

/* File: src/mtgs_chan_seq.sv */
// frame, word and channel sequencer driven by shift clock ticks
`timescale 1ns/10ps
`default_nettype none
module mtgs_chan_seq
    import mtgs_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              bit_tick,
    input  wire logic              frame_go,
    input  wire logic              stop_on_idle,
    input  wire logic [6:0]        last_word,
    input  wire logic [2:0]        word_len,
    output var  logic              active,
    output var  mtgs_pkg::mtgs_chan_t start_chan,
    output var  logic              word_start,
    output var  logic              bit_next,
    output var  logic              block_end,
    output var  logic              frame_done
);
    import mtgs_pkg::*;

    logic       active_q;
    mtgs_chan_t chan_q;
    logic [5:0] bit_q;
    logic       last_bit;
    logic       last_chan;
    logic       abort;
    logic       word_end;

    // ------------------------------------------------------------
    // word and frame boundaries
    // ------------------------------------------------------------
    always_comb begin
        last_bit   = bit_q == 6'(mtgs_word_bits(word_len) - 6'h01);
        last_chan  = chan_q == last_word;
        // slave enable dropped mid-word ends the frame at once
        abort      = active_q & stop_on_idle & ~frame_go;
        word_end   = bit_tick & active_q & last_bit & ~abort;
        word_start = bit_tick & ~abort
                   & ((~active_q & frame_go) | (word_end & ~last_chan));
        bit_next   = bit_tick & active_q & ~abort & ~last_bit;
        frame_done = (word_end & last_chan) | abort;
        // (RULE11) block end at 16-channel edge or frame end
        block_end  = word_end & ((chan_q[3:0] == MTGS_BLK_LAST) | last_chan);
        start_chan = active_q ? mtgs_chan_t'(chan_q + 7'h01) : '0;
        active     = active_q;
    end

    // (RULE23) channel counter per serial word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            active_q <= 1'b0;
            chan_q   <= '0;
            bit_q    <= 6'h00;
        end else if (abort) begin
            active_q <= 1'b0;
        end else if (word_start) begin
            active_q <= 1'b1;
            chan_q   <= start_chan;
            bit_q    <= 6'h00;
        end else if (word_end) begin
            active_q <= 1'b0;
        end else if (bit_next) begin
            bit_q    <= 6'(bit_q + 6'h01);
        end
    end

endmodule
`default_nettype wire

/* File: src/mtgs_pkg.sv */
// shared constants and helpers for the multichannel transmit gating block
package mtgs_pkg;

    // ------------------------------------------------------------
    // selection and interrupt mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MTGS_MODE_ALL      = 2'h0;
    localparam logic [1:0] MTGS_MODE_SEL_EN   = 2'h1;
    localparam logic [1:0] MTGS_MODE_SEL_MASK = 2'h2;
    localparam logic [1:0] MTGS_MODE_SYM      = 2'h3;

    localparam logic [1:0] MTGS_INTM_READY = 2'h0;
    localparam logic [1:0] MTGS_INTM_BLOCK = 2'h1;
    localparam logic [1:0] MTGS_INTM_FRAME = 2'h2;

    // ------------------------------------------------------------
    // widths, field positions, reset values, counts
    // ------------------------------------------------------------
    localparam int         MTGS_CH_W       = 7;
    localparam int         MTGS_NCH        = 128;
    localparam logic [5:0] MTGS_WORD_MAX   = 6'h20;
    localparam logic [3:0] MTGS_BLK_LAST   = 4'hf;
    localparam int         MTGS_WORD_MSB   = 31;
    localparam logic [1:0] MTGS_IRQ_CYCLES = 2'h2;
    localparam logic       MTGS_READY_RST  = 1'b1;
    localparam logic       MTGS_EMPTY_RST  = 1'b1;

    typedef logic [MTGS_CH_W-1:0] mtgs_chan_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // word length field to bit count (000b is eight bits)
    function automatic logic [5:0] mtgs_word_bits(input logic [2:0] wl);
        case (wl)
            3'h0:    mtgs_word_bits = 6'h08;
            3'h1:    mtgs_word_bits = 6'h0c;
            3'h2:    mtgs_word_bits = 6'h10;
            3'h3:    mtgs_word_bits = 6'h14;
            3'h4:    mtgs_word_bits = 6'h18;
            default: mtgs_word_bits = 6'h20;
        endcase
    endfunction

    // two-partition mode only reaches 32 enable bits
    function automatic mtgs_chan_t mtgs_chan_index(input logic eight,
                                                   input mtgs_chan_t ch);
        mtgs_chan_index = eight ? ch : {2'h0, ch[4:0]};
    endfunction

    // returns {enabled, unmasked}
    function automatic logic [1:0] mtgs_gate(input logic [1:0] mode,
                                             input logic       xbit,
                                             input logic       rbit);
        case (mode)
            MTGS_MODE_ALL:      mtgs_gate = 2'h3;
            MTGS_MODE_SEL_EN:   mtgs_gate = {xbit, xbit};
            MTGS_MODE_SEL_MASK: mtgs_gate = {1'b1, xbit};
            default:            mtgs_gate = {rbit, rbit & xbit};
        endcase
    endfunction

endpackage

/* File: src/mtgs_top.sv */
// multichannel transmit gating, block interrupts and clock stop mode
//
// Contract
// (RULE1) enabled channel copies holding register into shifter, starting it
// (RULE2) masked channel keeps data pin undriven, no bits shifted out
// (RULE3) disabled channel counts as masked and never drives the pin
// (RULE4) disabled channel: no copy, no ready flag, dma event, interrupt
// (RULE5) disabled channel leaves the empty flag untouched
// (RULE6) unmasked channel shifts the shifter out on the data pin
// (RULE7) software uses single-phase frames in multichannel modes
// (RULE8) frame length is words minus one; word length 000b is eight
// (RULE9) partition select 0 means two partitions, A and B only
// (RULE10) symmetric mode: software mirrors transmit framing into receive
// (RULE11) interrupt possible after every 16-channel block and frame end
// (RULE12) receive selection on, mode 01b: receive interrupt per block
// (RULE13) any transmit selection, mode 01b: transmit interrupt per block
// (RULE14) mode 01b without selection mode: no block interrupt
// (RULE15) block interrupts are active-high pulses of two clock cycles
// (RULE16) master supplies shift clock and slave enable; slave follows
// (RULE17) optional slave enable is active low, gates slave data
// (RULE18) without slave enable, active shift clock alone frames transfer
// (RULE19) master without slave enable: single, always-enabled slave
// (RULE20) clock stop: transmit clock and frame sync act as SPI pair
// (RULE21) clock stop: receive pins ignored, receiver tied to transmit
// (RULE22) selection mode decodes enable and mask per channel
// (RULE23) channel counter per word indexes enable and mask bits
`timescale 1ns/10ps
`default_nettype none
module mtgs_top
    import mtgs_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 tx_shift_clock,
    input  wire logic                 tx_frame_sync,
    input  wire logic                 rx_shift_clock,
    input  wire logic                 rx_frame_sync,
    input  wire logic                 clock_stop_mode,
    input  wire logic                 slave_enable_used,
    input  wire logic [1:0]           tx_selection_mode,
    input  wire logic                 tx_partition_count_select,
    input  wire logic                 tx_phase_select,
    input  wire logic [6:0]           tx_frame_length,
    input  wire logic [2:0]           tx_word_length,
    input  wire logic [1:0]           tx_interrupt_mode,
    input  wire logic [127:0]         tx_channel_enable_bits,
    input  wire logic                 rx_selection_mode,
    input  wire logic                 rx_partition_count_select,
    input  wire logic [6:0]           rx_frame_length,
    input  wire logic [2:0]           rx_word_length,
    input  wire logic [1:0]           rx_interrupt_mode,
    input  wire logic [127:0]         rx_channel_enable_bits,
    input  wire logic                 tx_write,
    input  wire logic [31:0]          tx_write_data,
    output var  logic                 serial_data_out_pin_o,
    output var  logic                 serial_data_out_pin_oe,
    output var  logic                 tx_ready_flag,
    output var  logic                 tx_empty_flag,
    output var  logic                 tx_dma_event,
    output var  logic                 tx_interrupt_request,
    output var  logic                 rx_interrupt_request,
    output var  mtgs_pkg::mtgs_chan_t tx_channel
);
    import mtgs_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // order: tx clock, tx sync, rx clock, rx sync
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [1:0] clk_prev_q;

    // (RULE16) slave side: master owns clock and sync
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_q    <= 4'h0;
            sync2_q    <= 4'h0;
            clk_prev_q <= 2'h0;
        end else begin
            sync1_q    <= {rx_frame_sync, rx_shift_clock,
                           tx_frame_sync, tx_shift_clock};
            sync2_q    <= sync1_q;
            clk_prev_q <= {sync2_q[2], sync2_q[0]};
        end
    end

    // ------------------------------------------------------------
    // framing sources
    // ------------------------------------------------------------
    logic tx_rise;
    logic rx_rise_pin;
    logic tx_go;
    logic rx_tick;
    logic rx_go;

    always_comb begin
        tx_rise     = sync2_q[0] & ~clk_prev_q[0];
        rx_rise_pin = sync2_q[2] & ~clk_prev_q[1];
        // (RULE20) frame sync becomes an active-low slave enable
        // (RULE18) no slave enable: the clock alone frames the word
        if (clock_stop_mode) begin
            tx_go = slave_enable_used ? ~sync2_q[1] : 1'b1;
        end else begin
            tx_go = sync2_q[1];
        end
        // (RULE21) receive pins ignored, receiver follows transmit
        rx_tick = clock_stop_mode ? tx_rise : rx_rise_pin;
        rx_go   = clock_stop_mode ? tx_go   : sync2_q[3];
    end

    // ------------------------------------------------------------
    // sequencers
    // ------------------------------------------------------------
    logic       tx_active;
    mtgs_chan_t tx_start_chan;
    logic       tx_start;
    logic       tx_bit;
    logic       tx_block_end;
    logic       tx_done;
    logic       rx_active;
    logic       rx_start;
    logic       rx_block_end;

    // (RULE8) frame length and word length fields feed the counters
    mtgs_chan_seq u_tx_seq (
        .clk          (clk),
        .reset        (reset),
        .bit_tick     (tx_rise),
        .frame_go     (tx_go),
        .stop_on_idle (clock_stop_mode),
        .last_word    (tx_frame_length),
        .word_len     (tx_word_length),
        .active       (tx_active),
        .start_chan   (tx_start_chan),
        .word_start   (tx_start),
        .bit_next     (tx_bit),
        .block_end    (tx_block_end),
        .frame_done   (tx_done)
    );

    mtgs_chan_seq u_rx_seq (
        .clk          (clk),
        .reset        (reset),
        .bit_tick     (rx_tick),
        .frame_go     (rx_go),
        .stop_on_idle (clock_stop_mode),
        .last_word    (rx_frame_length),
        .word_len     (rx_word_length),
        .active       (rx_active),
        .start_chan   (),
        .word_start   (rx_start),
        .bit_next     (),
        .block_end    (rx_block_end),
        .frame_done   ()
    );

    // ------------------------------------------------------------
    // channel enable and mask
    // ------------------------------------------------------------
    mtgs_chan_t tx_idx;
    logic [1:0] tx_gate;
    logic       copy;
    logic [31:0] word_src;
    logic [31:0] aligned;
    logic [31:0] holding_q;

    always_comb begin
        // (RULE9) partition select 0 limits the index to 32 channels
        tx_idx   = mtgs_chan_index(tx_partition_count_select,
                                   tx_start_chan);
        // (RULE22) per-channel enable and mask from selection mode
        tx_gate  = mtgs_gate(tx_selection_mode,
                             tx_channel_enable_bits[tx_idx],
                             rx_channel_enable_bits[tx_idx]);
        // (RULE4) no copy at all on a disabled channel
        copy     = tx_start & tx_gate[1];
        // a write landing with the copy is not lost
        word_src = tx_write ? tx_write_data : holding_q;
        aligned  = word_src << (MTGS_WORD_MAX
                                - mtgs_word_bits(tx_word_length));
    end

    // ------------------------------------------------------------
    // holding register and flags
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            holding_q <= 32'h0000_0000;
        end else if (tx_write) begin
            holding_q <= tx_write_data;
        end
    end
    // (RULE1) copy frees the holding register: ready set, set wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_ready_flag <= MTGS_READY_RST;
        end else if (copy) begin
            tx_ready_flag <= 1'b1;
        end else if (tx_write) begin
            tx_ready_flag <= 1'b0;
        end
    end
    // (RULE5) only an enabled copy of stale data marks empty
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_empty_flag <= MTGS_EMPTY_RST;
        end else if (copy & tx_ready_flag & ~tx_write) begin
            tx_empty_flag <= 1'b1;
        end else if (tx_write) begin
            tx_empty_flag <= 1'b0;
        end
    end
    // (RULE4) dma event only follows a real copy
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_dma_event <= 1'b0;
        end else begin
            tx_dma_event <= copy;
        end
    end

    // ------------------------------------------------------------
    // shifter and data pin
    // ------------------------------------------------------------
    logic [31:0] tx_shifter_q;
    // (RULE6) msb first, left-justified to the word length
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_shifter_q          <= 32'h0000_0000;
            serial_data_out_pin_o <= 1'b0;
        end else if (copy) begin
            tx_shifter_q          <= aligned << 1;
            serial_data_out_pin_o <= aligned[MTGS_WORD_MSB];
        end else if (tx_bit) begin
            tx_shifter_q          <= tx_shifter_q << 1;
            serial_data_out_pin_o <= tx_shifter_q[MTGS_WORD_MSB];
        end
    end
    // (RULE2) masked: shifting may run but the pin stays released
    // (RULE3) disabled implies masked through the enable term
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            serial_data_out_pin_oe <= 1'b0;
        end else if (tx_start) begin
            serial_data_out_pin_oe <= tx_gate[1] & tx_gate[0];
        end else if (tx_done) begin
            serial_data_out_pin_oe <= 1'b0;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_channel <= '0;
        end else if (tx_start) begin
            tx_channel <= tx_start_chan;
        end
    end

    // ------------------------------------------------------------
    // interrupt pulses
    // ------------------------------------------------------------
    logic       tx_mc_on;
    logic [1:0] irq_trig;
    logic [1:0] irq_cnt_q [2];
    logic [1:0] irq_q;
    always_comb begin
        tx_mc_on    = tx_selection_mode != MTGS_MODE_ALL;
        // (RULE13) (RULE14) block pulses need a selection mode on
        irq_trig[0] = (tx_interrupt_mode == MTGS_INTM_READY & copy)
                    | (tx_interrupt_mode == MTGS_INTM_BLOCK
                       & tx_mc_on & tx_block_end)
                    | (tx_interrupt_mode == MTGS_INTM_FRAME
                       & tx_start & ~tx_active);
        // (RULE12) receive block pulse with receive selection on
        irq_trig[1] = (rx_interrupt_mode == MTGS_INTM_BLOCK
                       & rx_selection_mode & rx_block_end)
                    | (rx_interrupt_mode == MTGS_INTM_FRAME
                       & rx_start & ~rx_active);
    end

    // (RULE15) each trigger stretched to exactly two cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_q <= 2'h0;
            for (int i = 0; i < 2; i++) begin
                irq_cnt_q[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                irq_q[i] <= irq_trig[i] | (irq_cnt_q[i] != 2'h0);
                if (irq_trig[i]) begin
                    irq_cnt_q[i] <= 2'(MTGS_IRQ_CYCLES - 2'h1);
                end else if (irq_cnt_q[i] != 2'h0) begin
                    irq_cnt_q[i] <= 2'(irq_cnt_q[i] - 2'h1);
                end
            end
        end
    end
    always_comb begin
        tx_interrupt_request = irq_q[0];
        rx_interrupt_request = irq_q[1];
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_copy_sets_ready: // RULE1
    assert property (@(posedge clk) disable iff (reset)
        copy |=> tx_ready_flag && tx_dma_event)
        else $error("copy did not set ready and dma event");
    a_masked_no_drive: // RULE2
    assert property (@(posedge clk) disable iff (reset)
        tx_start && tx_gate[1] && !tx_gate[0]
        |=> !serial_data_out_pin_oe [*1] ##0 tx_active)
        else $error("masked channel drives data pin");
    a_disabled_released: // RULE3
    assert property (@(posedge clk) disable iff (reset)
        tx_start && !tx_gate[1] |=> !serial_data_out_pin_oe)
        else $error("disabled channel drives data pin");
    a_disabled_no_flag: // RULE4
    assert property (@(posedge clk) disable iff (reset)
        tx_start && !tx_gate[1] && !tx_write
        |=> tx_ready_flag == $past(tx_ready_flag) && !tx_dma_event)
        else $error("disabled channel touched ready or dma");
    a_empty_kept: // RULE5
    assert property (@(posedge clk) disable iff (reset)
        tx_start && !tx_gate[1] && !tx_write
        |=> $stable(tx_empty_flag))
        else $error("disabled channel changed empty flag");
    a_unmasked_drives: // RULE6
    assert property (@(posedge clk) disable iff (reset)
        tx_start && tx_gate == 2'h3
        |=> serial_data_out_pin_oe
            && serial_data_out_pin_o == $past(aligned[MTGS_WORD_MSB]))
        else $error("unmasked channel not driven with first bit");
    a_rx_block_pulse: // RULE12
    assert property (@(posedge clk) disable iff (reset)
        rx_block_end && rx_selection_mode
        && rx_interrupt_mode == MTGS_INTM_BLOCK
        |=> rx_interrupt_request [*2])
        else $error("receive block interrupt missing");
    a_tx_block_pulse: // RULE13
    assert property (@(posedge clk) disable iff (reset)
        tx_block_end && tx_mc_on
        && tx_interrupt_mode == MTGS_INTM_BLOCK
        |=> tx_interrupt_request [*2])
        else $error("transmit block interrupt missing");
    a_no_block_irq: // RULE14
    assert property (@(posedge clk) disable iff (reset)
        tx_interrupt_mode == MTGS_INTM_BLOCK && !tx_mc_on
        && $stable(tx_interrupt_mode) && $stable(tx_selection_mode)
        && !tx_interrupt_request
        |=> !tx_interrupt_request)
        else $error("block interrupt without selection mode");
    a_pulse_width: // RULE15
    assert property (@(posedge clk) disable iff (reset)
        $rose(tx_interrupt_request) && !irq_trig[0]
        |=> tx_interrupt_request ##1 !tx_interrupt_request)
        else $error("transmit interrupt pulse not two cycles");
    a_stop_rx_tied: // RULE21
    assert property (@(posedge clk) disable iff (reset)
        clock_stop_mode |-> rx_tick == tx_rise && rx_go == tx_go)
        else $error("receiver not tied to transmit in clock stop");

endmodule
`default_nettype wire
